// [logic/modem_bus_pkg.sv]
// package: constants and carrier types for the modem host bus interface
package modem_bus_pkg;
    // address field of the muxed lines, bits 4..1
    localparam int ADDR_LSB      = 1;
    localparam int ADDR_MSB      = 4;
    localparam int ADDR_W        = 4;
    localparam int CTRL_BIT      = 3;
    // control register indexes; only TONE bit 1 reads back
    localparam logic [3:0] ADDR_TXCR  = 4'h8;
    localparam logic [3:0] ADDR_MCRA  = 4'h9;
    localparam logic [3:0] ADDR_MCRB  = 4'hA;
    localparam logic [3:0] ADDR_TONE  = 4'hB;
    localparam logic [3:0] ADDR_PGCR  = 4'hC;
    localparam logic [3:0] ADDR_DATA  = 4'hD;
    localparam logic [3:0] ADDR_AUDIO = 4'hE;
    // read registers
    localparam logic [3:0] ADDR_Q1     = 4'h0;
    localparam logic [3:0] ADDR_I1     = 4'h1;
    localparam logic [3:0] ADDR_Q2     = 4'h2;
    localparam logic [3:0] ADDR_I2     = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] OE_NONE     = 8'h00;
    localparam logic [7:0] OE_ALL      = 8'hFF;
    // idle level of each synchronised pin, in synchroniser bit order
    localparam logic [16:0] PIN_IDLE   = 17'h16005;
    // TXCR, TONE and AUDIO register fields
    localparam int TXCR_BR0      = 0;
    localparam int TXCR_SYNC_BIT = 4;
    localparam int TXCR_V23      = 7;
    localparam int TXSEL_LSB     = 3;
    localparam int TONE_RW_BIT   = 1;
    localparam int AUDIO_ALC_LSB = 0;
    // timing
    localparam int  CLK_HZ       = 200_000_000;
    localparam real INT_PULSE_US = 13.0;
    localparam int  INT_CYCLES   = int'(INT_PULSE_US * 200.0);
    localparam int  TXCLK_1200_HZ = 1200;
    localparam int  TXCLK_2400_HZ = 2400;
    localparam int  HALF_1200    = CLK_HZ / (2 * TXCLK_1200_HZ);
    localparam int  HALF_2400    = CLK_HZ / (2 * TXCLK_2400_HZ);
    localparam int  CNT_W        = 17;

    typedef struct packed {
        logic       cs_n;
        logic       ale;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] ad;
    } bus_pins_s;

    typedef struct packed {
        logic [7:0] q1;
        logic [7:0] i1;
        logic [7:0] q2;
        logic [7:0] i2;
        logic [7:0] status;
    } samples_s;

    typedef enum logic [2:0] {
        TXSRC_SERIAL  = 3'b001,
        TXSRC_SPECIAL = 3'b010,
        TXSRC_IDLE    = 3'b100
    } txsrc_e;
endpackage : modem_bus_pkg

// [logic/modem_host_bus_interface.sv]
// modem host bus interface: muxed register port, int pulse, sync clocks
`timescale 1ns/100ps
module modem_host_bus_interface (
    input  wire logic                    CLK_SYS,
    input  wire logic                    RST_N,
    input  wire modem_bus_pkg::bus_pins_s BUS_IN,
    output logic [7:0]                   AD_OUT,
    output logic [7:0]                   AD_OE,
    input  wire modem_bus_pkg::samples_s SAMPLES,
    input  wire logic                    CONV_DONE,
    input  wire logic                    RX_PLL_CLK,
    input  wire logic                    RX_DATA_IN,
    input  wire logic                    EXTERNAL_TRANSMIT_CLOCK,
    input  wire logic                    SERIAL_TXD,
    input  wire logic                    CONTROLLER_SPECIAL_TX_OUT,
    output logic                         INTERRUPT,
    output logic                         RECOVERED_RECEIVE_CLOCK,
    output logic                         RX_DATA_OUT,
    output logic                         INTERNAL_TRANSMIT_CLOCK,
    output logic                         TX_BIT,
    output logic                         TX_BIT_VALID,
    output logic [1:0]                   AUDIO_ATTEN,
    output logic [7:0]                   TXCR_OUT
);
    import modem_bus_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 17;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] meta_reg;
    logic [NSYNC-1:0] sync_reg;
    logic [NSYNC-1:0] prev_reg;
    assign pins_raw = {BUS_IN.cs_n, BUS_IN.ale, BUS_IN.wr_n, BUS_IN.rd_n,
                       BUS_IN.ad, CONV_DONE, RX_PLL_CLK, RX_DATA_IN,
                       EXTERNAL_TRANSMIT_CLOCK, SERIAL_TXD};

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            // idle levels, so no edge detector sees a false edge at release
            meta_reg <= PIN_IDLE;
            sync_reg <= PIN_IDLE;
            prev_reg <= PIN_IDLE;
        end else begin
            meta_reg <= pins_raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    logic       cs_n_s, ale_s, wr_n_s, rd_n_s, conv_s, rxclk_s, rxd_s;
    logic       extclk_s, txd_s, ale_prev, wr_prev, conv_prev, extclk_prev;
    logic [7:0] ad_s;
    assign {cs_n_s, ale_s, wr_n_s, rd_n_s, ad_s, conv_s, rxclk_s, rxd_s,
            extclk_s, txd_s} = sync_reg;
    assign ale_prev    = prev_reg[15];
    assign wr_prev     = prev_reg[14];
    assign conv_prev   = prev_reg[4];
    assign extclk_prev = prev_reg[1];

    logic ale_fall, wr_rise, conv_rise, extclk_rise;
    assign ale_fall    = ale_prev && !ale_s && !cs_n_s;
    assign wr_rise     = !wr_prev && wr_n_s && !prev_reg[16];
    assign conv_rise   = conv_s && !conv_prev;
    assign extclk_rise = extclk_s && !extclk_prev;

    // ------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] addr_reg;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            addr_reg <= '0;
        end else if (ale_fall) begin
            addr_reg <= ad_s[ADDR_MSB:ADDR_LSB];
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // address F has no storage, so its writes fall away
    logic [7:0] ctrl_reg [0:6];
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_ctrl
            always_ff @(posedge CLK_SYS or negedge RST_N) begin
                if (!RST_N) begin
                    ctrl_reg[gi] <= REG_RESET;
                end else if (wr_rise && addr_reg[CTRL_BIT]
                             && addr_reg[2:0] == 3'(gi)) begin
                    ctrl_reg[gi] <= ad_s;
                end
            end
        end
    endgenerate

    logic [7:0] txcr, tone;
    assign txcr = ctrl_reg[ADDR_TXCR[2:0]];
    assign tone = ctrl_reg[ADDR_TONE[2:0]];

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rd_data_next, rd_oe_next, ad_out_reg, ad_oe_reg;
    always_comb begin
        rd_data_next = 8'h00;
        rd_oe_next   = OE_ALL;
        case (addr_reg)
            ADDR_Q1:     rd_data_next = SAMPLES.q1;
            ADDR_I1:     rd_data_next = SAMPLES.i1;
            ADDR_Q2:     rd_data_next = SAMPLES.q2;
            ADDR_I2:     rd_data_next = SAMPLES.i2;
            ADDR_STATUS: rd_data_next = SAMPLES.status;
            ADDR_TONE: begin
                rd_data_next = tone & 8'h02;
                rd_oe_next   = 8'h02;
            end
            default:     rd_oe_next = OE_NONE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ad_out_reg <= 8'h00;
            ad_oe_reg  <= OE_NONE;
        end else if (!cs_n_s && !rd_n_s) begin
            ad_out_reg <= rd_data_next;
            ad_oe_reg  <= rd_oe_next;
        end else begin
            ad_oe_reg  <= OE_NONE;
        end
    end
    assign AD_OUT = ad_out_reg;
    assign AD_OE  = ad_oe_reg;

    // ------------------------------------------------------------
    // interrupt pulse
    // ------------------------------------------------------------
    logic [CNT_W-1:0] int_cnt_reg;
    logic             int_reg;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            int_cnt_reg <= '0;
            int_reg     <= 1'b0;
        end else if (conv_rise) begin
            int_cnt_reg <= CNT_W'(INT_CYCLES - 1);
            int_reg     <= 1'b1;
        end else if (int_cnt_reg != '0) begin
            int_cnt_reg <= int_cnt_reg - 1'b1;
        end else begin
            int_reg <= 1'b0;
        end
    end
    assign INTERRUPT = int_reg;

    // ------------------------------------------------------------
    // synchronous serial path
    // ------------------------------------------------------------
    logic sync_mode;
    assign sync_mode = txcr[TXCR_SYNC_BIT];

    logic rxclk_reg, rxd_reg;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rxclk_reg <= 1'b0;
            rxd_reg   <= 1'b1;
        end else begin
            // clock out only in sync mode
            rxclk_reg <= sync_mode & rxclk_s;
            rxd_reg   <= rxd_s;
        end
    end
    assign RECOVERED_RECEIVE_CLOCK = rxclk_reg;
    assign RX_DATA_OUT             = rxd_reg;

    // BR0 set selects 2400, clear selects 1200: divider error is well under 0.01 percent
    logic [CNT_W-1:0] div_reg;
    logic             txclk_reg;
    logic [CNT_W-1:0] half;
    assign half = txcr[TXCR_BR0] ? CNT_W'(HALF_2400) : CNT_W'(HALF_1200);
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            div_reg   <= '0;
            txclk_reg <= 1'b0;
        end else if (!sync_mode) begin
            div_reg   <= '0;
            txclk_reg <= 1'b0;
        end else if (div_reg >= half - 1'b1) begin
            div_reg   <= '0;
            txclk_reg <= ~txclk_reg;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    assign INTERNAL_TRANSMIT_CLOCK = txclk_reg;

    txsrc_e txsrc;
    always_comb begin
        if (txcr[TXCR_V23])
            txsrc = TXSRC_SPECIAL;
        else
            txsrc = TXSRC_SERIAL;
    end

    logic spec_m_reg, spec_s_reg, tx_bit_reg, tx_valid_reg, tx_src_bit;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            spec_m_reg <= 1'b1;
            spec_s_reg <= 1'b1;
        end else begin
            spec_m_reg <= CONTROLLER_SPECIAL_TX_OUT;
            spec_s_reg <= spec_m_reg;
        end
    end

    always_comb begin
        case (txsrc)
            TXSRC_SERIAL:  tx_src_bit = txd_s;
            TXSRC_SPECIAL: tx_src_bit = spec_s_reg;
            default:       tx_src_bit = 1'b1;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            tx_bit_reg   <= 1'b1;
            tx_valid_reg <= 1'b0;
        end else if (sync_mode && extclk_rise) begin
            tx_bit_reg   <= tx_src_bit;
            tx_valid_reg <= 1'b1;
        end else if (!sync_mode) begin
            tx_bit_reg   <= tx_src_bit;
            tx_valid_reg <= 1'b0;
        end else begin
            tx_valid_reg <= 1'b0;
        end
    end
    assign TX_BIT       = tx_bit_reg;
    assign TX_BIT_VALID = tx_valid_reg;

    logic [1:0] audio_reg;
    logic [7:0] txcr_reg;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            audio_reg <= 2'h0;
            txcr_reg  <= REG_RESET;
        end else begin
            audio_reg <= ctrl_reg[ADDR_AUDIO[2:0]][AUDIO_ALC_LSB +: 2];
            txcr_reg  <= txcr;
        end
    end
    assign AUDIO_ATTEN = audio_reg;
    assign TXCR_OUT    = txcr_reg;
endmodule : modem_host_bus_interface

// [tb/host_ctrl_model.sv]
// partner model: controller side of the muxed register bus
`timescale 1ns/100ps
module host_ctrl_model (
    input  wire logic                CLK_SYS,
    input  wire logic [7:0]          AD_OUT,
    input  wire logic [7:0]          AD_OE,
    output modem_bus_pkg::bus_pins_s BUS_IN
);
    import modem_bus_pkg::*;
    logic       cs_n = 1'b1, ale = 1'b0, wr_n = 1'b1, rd_n = 1'b1, en = 1'b0;
    logic [7:0] drv = 8'h00, last = 8'h00;
    // released lines show a level that changes every cycle
    assign BUS_IN = {cs_n, ale, wr_n, rd_n,
                     (AD_OE & AD_OUT) | (~AD_OE & (en ? drv : ~last))};
    always @(posedge CLK_SYS) last <= BUS_IN.ad;
    task automatic step(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : step
    // select, address on middle lines, junk on the others
    task automatic addr(input logic [3:0] a, input logic sel);
        cs_n = ~sel;
        ale = 1'b1;
        drv = {~a[3:1], a, ~a[0]};
        en = 1'b1;
        step(5);
        ale = 1'b0;
        step(5);
    endtask : addr
    // data held until after the write strobe rises
    task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic sel);
        addr(a, sel);
        drv = v;
        wr_n = 1'b0;
        step(10);
        wr_n = 1'b1;
        step(5);
        en = 1'b0;
        cs_n = 1'b1;
        step(5);
    endtask : wr
    // byte taken at the strobe rise; na low reuses the address
    task automatic rd(input logic [3:0] a, input logic na,
                      output logic [7:0] d, output logic [7:0] oe);
        if (na) addr(a, 1'b1);
        en = 1'b0;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (10) @(posedge CLK_SYS);
        d = BUS_IN.ad;
        oe = AD_OE;
        #1;
        rd_n = 1'b1;
        cs_n = 1'b1;
        step(5);
    endtask : rd
endmodule : host_ctrl_model

// [tb/modem_host_bus_interface_chk.sv]
// checker: port timing of the modem host bus interface
`timescale 1ns/100ps
module bus_if_chk (
    input wire logic                     CLK_SYS,
    input wire logic                     RST_N,
    input wire modem_bus_pkg::bus_pins_s BUS_IN,
    input wire logic [7:0]               AD_OE,
    input wire logic                     CONV_DONE,
    input wire logic                     INTERRUPT,
    input wire logic                     RECOVERED_RECEIVE_CLOCK,
    input wire logic                     INTERNAL_TRANSMIT_CLOCK,
    input wire logic                     TX_BIT_VALID,
    input wire logic [1:0]               AUDIO_ATTEN,
    input wire logic [7:0]               TXCR_OUT
);
    import modem_bus_pkg::*;
    int unsigned hi_reg;
    logic        sel;
    assign sel = !BUS_IN.cs_n && !BUS_IN.rd_n;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // --------------------------------------------------------------
    // pulse width counter and assertions
    // --------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) hi_reg <= 0;
        else hi_reg <= INTERRUPT ? hi_reg + 1 : 0;
    end
    a_oe_needs_select: assert property (
        |AD_OE |-> $past(sel, 3) || $past(sel, 4))
        else $error("data lines driven while not selected for read");
    // synchroniser delay means drive cannot appear on the strobe edge itself
    a_oe_rise_read: assert property (
        $rose(|AD_OE) |-> sel && $past(sel, 2))
        else $error("drive began without a held read strobe");
    a_oe_unused_bits: assert property (
        |AD_OE |-> AD_OE == OE_ALL || AD_OE == 8'h02)
        else $error("unused register bits driven");
    a_int_width: assert property (
        $fell(INTERRUPT) |-> hi_reg == INT_CYCLES)
        else $error("interrupt pulse width wrong");
    a_int_cause: assert property (
        $rose(CONV_DONE) |-> ##[1:8] $rose(INTERRUPT))
        else $error("no interrupt after conversions done");
    a_rx_clock_gated: assert property (
        !TXCR_OUT[TXCR_SYNC_BIT] [*3] |-> !RECOVERED_RECEIVE_CLOCK)
        else $error("receive clock out of sync mode");
    a_tx_clock_gated: assert property (
        !TXCR_OUT[TXCR_SYNC_BIT] [*3] |-> !INTERNAL_TRANSMIT_CLOCK)
        else $error("transmit clock out of sync mode");
    a_tx_valid_pulse: assert property (
        TX_BIT_VALID |-> TXCR_OUT[TXCR_SYNC_BIT] ##1 !TX_BIT_VALID)
        else $error("tx sample pulse wrong");
    a_write_needs_cs: assert property (
        $changed(AUDIO_ATTEN) || $changed(TXCR_OUT) |-> !$past(BUS_IN.cs_n, 4))
        else $error("control register changed without select");
    c_int: cover property ($rose(INTERRUPT));
    c_read: cover property ($rose(|AD_OE));
    c_tx: cover property (TX_BIT_VALID);
endmodule : bus_if_chk
bind modem_host_bus_interface bus_if_chk u_bus_if_chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .BUS_IN(BUS_IN), .AD_OE(AD_OE),
    .CONV_DONE(CONV_DONE), .INTERRUPT(INTERRUPT),
    .RECOVERED_RECEIVE_CLOCK(RECOVERED_RECEIVE_CLOCK),
    .INTERNAL_TRANSMIT_CLOCK(INTERNAL_TRANSMIT_CLOCK),
    .TX_BIT_VALID(TX_BIT_VALID), .AUDIO_ATTEN(AUDIO_ATTEN),
    .TXCR_OUT(TXCR_OUT));

// [tb/tb.sv]
// testbench: drives the modem host bus interface through its ports
`timescale 1ns/100ps
module tb;
    import modem_bus_pkg::*;
    logic       CLK_SYS, RST_N, cdone, rpll, rdin, xclk, txd, spc;
    logic       intr, rclk, rdout, iclk, tbit, tvld;
    bus_pins_s  bus;
    samples_s   smp;
    logic [7:0] ad_out, ad_oe, txcr, d, oe;
    logic [1:0] atten;
    int         fails = 0, checks_done = 0, cycles = 0;
    initial begin
        CLK_SYS = 1'b0;
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end
    host_ctrl_model u_host_ctrl_model (.CLK_SYS(CLK_SYS), .AD_OUT(ad_out),
        .AD_OE(ad_oe), .BUS_IN(bus));
    modem_host_bus_interface u_modem_host_bus_interface (.CLK_SYS(CLK_SYS),
        .RST_N(RST_N), .BUS_IN(bus), .AD_OUT(ad_out), .AD_OE(ad_oe),
        .SAMPLES(smp), .CONV_DONE(cdone), .RX_PLL_CLK(rpll),
        .RX_DATA_IN(rdin), .EXTERNAL_TRANSMIT_CLOCK(xclk), .SERIAL_TXD(txd),
        .CONTROLLER_SPECIAL_TX_OUT(spc), .INTERRUPT(intr),
        .RECOVERED_RECEIVE_CLOCK(rclk), .RX_DATA_OUT(rdout),
        .INTERNAL_TRANSMIT_CLOCK(iclk), .TX_BIT(tbit), .TX_BIT_VALID(tvld),
        .AUDIO_ATTEN(atten), .TXCR_OUT(txcr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : step
    task automatic finish_test;
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 95000) begin
            fails++;
            finish_test();
        end
    end
    task automatic t_regs;
        chk(32'(txcr), 32'(REG_RESET));
        for (int i = 0; i < 4; i++) begin
            u_host_ctrl_model.wr(ADDR_AUDIO, 8'hF0 | 8'(i), 1'b1);
            chk(32'(atten), 32'(i));
        end
        u_host_ctrl_model.wr(ADDR_AUDIO, 8'h01, 1'b0);
        chk(32'(atten), 32'h3);
        $display("test regs done");
    endtask : t_regs
    task automatic t_read;
        smp = {8'h11, 8'h22, 8'h33, 8'h44, 8'hA5};
        u_host_ctrl_model.wr(ADDR_TONE, 8'hFF, 1'b1);
        for (int a = 0; a < 16; a++) begin
            u_host_ctrl_model.rd(4'(a), 1'b1, d, oe);
            chk(32'(oe), a < 5 ? 32'hFF : a == 11 ? 32'h02 : 32'h0);
            if (a < 5) chk(32'(d), 32'(smp >> (8 * (4 - a))) & 32'hFF);
            if (a == 11) chk(32'(d & 8'h02), 32'h02);
        end
        u_host_ctrl_model.rd(4'h0, 1'b0, d, oe);
        chk(32'(oe), 32'h0);
        $display("test read done");
    endtask : t_read
    task automatic t_int;
        int n = 0;
        cdone = 1'b1;
        while (intr !== 1'b1 && n < 10) begin step(1); n++; end
        n = 0;
        while (intr === 1'b1 && n < 3000) begin step(1); n++; end
        chk(32'(n), 32'(INT_CYCLES));
        cdone = 1'b0;
        $display("test int done");
    endtask : t_int
    task automatic send_bit(input logic b, input logic sp);
        int n = 0;
        txd = sp ? ~b : b;
        spc = sp ? b : ~b;
        step(8);
        xclk = 1'b1;
        while (tvld !== 1'b1 && n < 20) begin step(1); n++; end
        chk(32'(tbit), 32'(b));
        step(8 - n);
        xclk = 1'b0;
    endtask : send_bit
    task automatic t_sync;
        int  n = 0;
        logic c0;
        rpll = 1'b1;
        rdin = 1'b1;
        step(6);
        chk(32'({rclk, rdout}), 32'h1);
        u_host_ctrl_model.wr(ADDR_TXCR, 8'h11, 1'b1);
        chk(32'({txcr, rclk}), 32'h23);
        rpll = 1'b0;
        rdin = 1'b0;
        step(4);
        chk(32'({rclk, rdout}), 32'h0);
        for (int i = 0; i < 4; i++) send_bit(i[0], 1'b0);
        u_host_ctrl_model.wr(ADDR_TXCR, 8'h91, 1'b1);
        for (int i = 0; i < 4; i++) send_bit(~i[0], 1'b1);
        c0 = iclk;
        while (iclk === c0 && n < 42000) begin step(1); n++; end
        c0 = iclk;
        n = 0;
        while (iclk === c0 && n < 42000) begin step(1); n++; end
        chk(32'(n >= HALF_2400 - 2 && n <= HALF_2400 + 2), 32'h1);
        rpll = 1'b1;
        u_host_ctrl_model.wr(ADDR_TXCR, 8'h00, 1'b1);
        chk(32'({iclk, rclk}), 32'h0);
        $display("test sync done");
    endtask : t_sync
    initial begin
        RST_N = 1'b0;
        {cdone, rpll, rdin, xclk, txd, spc} = 6'h00;
        smp = '0;
        step(2);
        RST_N = 1'b1;
        step(3);
        t_regs();
        t_read();
        t_int();
        t_sync();
        finish_test();
    end
endmodule : tb
